// *** verilog/dram_power_down_control.sv ***
// power-down entry, exit and flavour tracking of the dram core
`timescale 1ns/1ps
module dram_power_down_control
  import pd_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic                 gate_pin,
  input  wire pd_pkg::core_stat_t   core_stat,
  input  wire logic [7:0]           termination_mode_field,
  input  wire logic                 rank_term_en,
  output pd_pkg::pd_ctl_t           ctl,
  output pd_pkg::pd_flavour_t       flavour,
  output logic                      in_power_down,
  output logic                      pending_ops
);
  ////////////////////////////////////////////////////////////////
  // pin synchroniser: first stage feeds only the second
  logic gate_s1_r;
  logic gate_s2_r;
  logic gate_d_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_s1_r <= 1'b1;
      gate_s2_r <= 1'b1;
      gate_d_r  <= 1'b1;
    end else begin
      gate_s1_r <= gate_pin;
      gate_s2_r <= gate_s1_r;
      gate_d_r  <= gate_s2_r;
    end
  end

  wire gate_fall = gate_d_r && !gate_s2_r;
  wire gate_rise = !gate_d_r && gate_s2_r;

  ////////////////////////////////////////////////////////////////
  // state machine
  typedef enum logic [2:0] {ST_ACTIVE, ST_ENTRY_HOLD, ST_DOWN, ST_EXIT} pd_state_t;
  pd_state_t state_r;
  pd_state_t state_nxt;

  logic entry_done;
  logic exit_done;
  logic [CNT_W-1:0] entry_cnt;
  logic [CNT_W-1:0] exit_cnt;

  assign entry_cnt = CNT_W'(ENTRY_HOLD_CYC - 1);
  assign exit_cnt  = CNT_W'(EXIT_LAT_CYC - 1);

  // clock hold window after entry, then receivers go off
  pd_timer #(.W(CNT_W)) u_entry (
    .clk    (clk),
    .arst_n (arst_n),
    .load   (gate_fall),
    .count  (entry_cnt),
    .done   (entry_done)
  );

  // exit latency before commands are accepted
  pd_timer #(.W(CNT_W)) u_exit (
    .clk    (clk),
    .arst_n (arst_n),
    .load   (gate_rise),
    .count  (exit_cnt),
    .done   (exit_done)
  );

  // entry and exit follow the pin level; a rise during hold aborts at once
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_ACTIVE:     if (gate_fall) state_nxt = ST_ENTRY_HOLD;
      ST_ENTRY_HOLD: begin
        if (gate_rise) state_nxt = ST_EXIT;
        else if (entry_done) state_nxt = ST_DOWN;
      end
      ST_DOWN:       if (gate_rise) state_nxt = ST_EXIT;
      ST_EXIT: begin
        if (gate_fall) state_nxt = ST_ENTRY_HOLD;
        else if (exit_done) state_nxt = ST_ACTIVE;
      end
      default:       state_nxt = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state_r <= ST_ACTIVE;
    else state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////
  // flavour is fixed at the moment of entry
  pd_flavour_t flav_r;
  pd_flavour_t flav_nxt;
  wire pd_level = (state_r == ST_ENTRY_HOLD) || (state_r == ST_DOWN);

  assign flav_nxt = gate_fall ? (core_stat.self_refresh ? FL_SELF
                               : core_stat.banks_open   ? FL_ACTIVE
                                                        : FL_IDLE)
                  : (gate_rise ? FL_NONE : flav_r);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) flav_r <= FL_NONE;
    else flav_r <= flav_nxt;
  end

  ////////////////////////////////////////////////////////////////
  // operations in flight keep running through entry; the core
  // sees no gating from this block, only the flag below
  assign pending_ops = pd_level && (core_stat.act_busy || core_stat.pre_busy
                       || core_stat.ref_busy || core_stat.cal_busy);

  wire [TERM_W-1:0] term_bits = termination_mode_field[TERM_LSB +: TERM_W];

  assign ctl.bufs_on    = !pd_level && (state_r != ST_EXIT || exit_done);
  assign ctl.rx_on      = state_r != ST_DOWN;
  assign ctl.cmd_ok     = state_r == ST_ACTIVE;
  // refresh stays on only in self-refresh power-down
  assign ctl.refresh_ok = !pd_level || (flav_r == FL_SELF);
  // termination ignores power-down state entirely
  assign ctl.term_on    = rank_term_en && (term_bits != '0);

  assign flavour       = flav_r;
  assign in_power_down = pd_level;
endmodule

// *** common/pd_pkg.sv ***
// shared constants and carrier types for the power-down control block
// Operation
// - power-down entered when clock enable falls, left when it rises
// - device accepts entry during activate, precharge or refresh and finishes them
// - entry disables input and output buffers except clock enable and reset
// - clock held for hold window after entry; then receivers off except reset
// - no refresh in power-down except self-refresh power-down
// - commands accepted only after exit latency max(7.5 ns, 5 cycles)
// - power-down flavour is idle, active or self-refresh
// - enabled command-bus termination persists in every state including power-down
// - calibration continues if entry comes after calibration window
package pd_pkg;
  localparam int CLK_PS         = 4000;
  localparam int ENTRY_HOLD_PS  = 5000;
  localparam int ENTRY_HOLD_NCK = 5;
  localparam int EXIT_LAT_PS    = 7500;
  localparam int EXIT_LAT_NCK   = 5;
  localparam int MIN_PULSE_PS   = 7500;
  localparam int MIN_PULSE_NCK  = 4;
  localparam int CMD_ENTRY_PS   = 1750;
  localparam int CMD_ENTRY_NCK  = 3;
  localparam int MRW_ENTRY_PS   = 14000;
  localparam int MRW_ENTRY_NCK  = 10;
  localparam int CAL_ENTRY_PS   = 1750;
  localparam int CAL_ENTRY_NCK  = 3;
  // least times round up, and both the time and the count must pass
  function automatic int cyc(input int ps, input int nck);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c > nck) ? c : nck;
  endfunction
  localparam int ENTRY_HOLD_CYC = cyc(ENTRY_HOLD_PS, ENTRY_HOLD_NCK);
  localparam int EXIT_LAT_CYC   = cyc(EXIT_LAT_PS, EXIT_LAT_NCK);
  localparam int MIN_PULSE_CYC  = cyc(MIN_PULSE_PS, MIN_PULSE_NCK);
  localparam int CMD_ENTRY_CYC  = cyc(CMD_ENTRY_PS, CMD_ENTRY_NCK);
  localparam int MRW_ENTRY_CYC  = cyc(MRW_ENTRY_PS, MRW_ENTRY_NCK);
  localparam int CAL_ENTRY_CYC  = cyc(CAL_ENTRY_PS, CAL_ENTRY_NCK);
  localparam int CNT_W          = 5;
  localparam int TERM_LSB       = 4;
  localparam int TERM_W         = 3;

  typedef enum logic [1:0] {FL_NONE, FL_IDLE, FL_ACTIVE, FL_SELF} pd_flavour_t;

  typedef struct packed {
    logic banks_open;
    logic self_refresh;
    logic act_busy;
    logic pre_busy;
    logic ref_busy;
    logic cal_busy;
  } core_stat_t;

  typedef struct packed {
    logic bufs_on;
    logic rx_on;
    logic cmd_ok;
    logic refresh_ok;
    logic term_on;
  } pd_ctl_t;
endpackage

// *** verilog/pd_timer.sv ***
// down counter that reports when a loaded count has run out
`timescale 1ns/1ps
module pd_timer #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = load ? count : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign done    = (cnt_r == '0) && !load;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end
endmodule

// *** verification/pd_checker.sv ***
// port assertions for the power-down control block
`timescale 1ns/1ps
module pd_checker
  import pd_pkg::*;
(
  input wire logic                clk,
  input wire logic                arst_n,
  input wire logic                gate_pin,
  input wire pd_pkg::core_stat_t  core_stat,
  input wire logic [7:0]          termination_mode_field,
  input wire logic                rank_term_en,
  input wire pd_pkg::pd_ctl_t     ctl,
  input wire pd_pkg::pd_flavour_t flavour,
  input wire logic                in_power_down,
  input wire logic                pending_ops
);
  import pd_pkg::*;
  pd_flavour_t fl_exp;
  assign fl_exp = core_stat.self_refresh ? FL_SELF : core_stat.banks_open ? FL_ACTIVE : FL_IDLE;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  entry_delay_a: assert property ($fell(gate_pin) |-> ##[3:4] in_power_down)
    else $error("entry not seen in time");
  exit_delay_a: assert property ($rose(gate_pin) |-> ##[3:4] !in_power_down)
    else $error("exit not seen in time");
  buffers_off_a: assert property (in_power_down |-> !ctl.bufs_on)
    else $error("buffers on in power-down");
  rx_hold_a: assert property ($rose(in_power_down) |-> ctl.rx_on [*5] ##1 !ctl.rx_on)
    else $error("receiver hold window wrong");
  exit_latency_a: assert property ($fell(in_power_down) |-> !ctl.cmd_ok [*5] ##1 ctl.cmd_ok)
    else $error("exit latency wrong");
  no_refresh_a: assert property (in_power_down |-> ctl.refresh_ok == (flavour == FL_SELF))
    else $error("refresh in power-down");
  flavour_pick_a: assert property ($rose(in_power_down) |-> flavour == $past(fl_exp))
    else $error("wrong flavour");
  term_keep_a: assert property ($stable(rank_term_en) && $stable(termination_mode_field)
    |-> ctl.term_on == (rank_term_en && |termination_mode_field[6:4]))
    else $error("termination wrong");
  ops_finish_a: assert property (pending_ops == (in_power_down &&
    |{core_stat.act_busy, core_stat.pre_busy, core_stat.ref_busy, core_stat.cal_busy}))
    else $error("pending flag wrong");
endmodule
bind dram_power_down_control pd_checker CHK (.clk, .arst_n, .gate_pin, .core_stat,
  .termination_mode_field, .rank_term_en, .ctl, .flavour, .in_power_down, .pending_ops);

// *** verification/ctrl_model.sv ***
// controller model pacing the clock-enable pin
`timescale 1ns/1ps
module ctrl_model
  import pd_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic want_low,
  output logic      gate_pin
);
  import pd_pkg::*;
  logic [3:0] held_r;
  // chip select is not a pin here; the model issues no command around either edge
  // so select stays idle through the entry and exit windows
  // a change waits until the old level has lasted the minimum pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_pin <= 1'b1;
      held_r   <= 4'h0;
    end else if (gate_pin == want_low && held_r >= MIN_PULSE_CYC - 1) begin
      gate_pin <= ~want_low;
      held_r   <= 4'h0;
    end else if (held_r != 4'hf) begin
      held_r <= held_r + 4'h1;
    end
  end
endmodule

// *** verification/dram_power_down_control_tb_top.sv ***
// self-checking bench for the power-down control block
`timescale 1ns/1ps
module dram_power_down_control_tb_top;
  import pd_pkg::*;
  logic        clk, arst_n, want_low, gate_pin, rank_term_en, in_power_down, pending_ops, last_pd;
  logic [7:0]  termination_mode_field;
  core_stat_t  core_stat;
  pd_ctl_t     ctl;
  pd_flavour_t flavour, fl;
  logic [7:0]  q[$];
  int          failures, n_checks, cycles;
  ctrl_model CM (.clk, .arst_n, .want_low, .gate_pin);
  dram_power_down_control DUT (.clk, .arst_n, .gate_pin, .core_stat, .termination_mode_field,
    .rank_term_en, .ctl, .flavour, .in_power_down, .pending_ops);
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
    #1;
    if (arst_n && in_power_down !== last_pd) chk("pd_flavour", {5'h0, in_power_down, flavour}, q.pop_front());
    last_pd = in_power_down;
  end
  initial begin
    arst_n = 0; want_low = 0; core_stat = '0;
    termination_mode_field = 8'h00; rank_term_en = 0;
    void'($urandom(27390));
    repeat (2) @(posedge clk);
    arst_n <= 1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      core_stat <= core_stat_t'(6'($urandom));
      termination_mode_field <= 8'($urandom);
      rank_term_en <= 1'($urandom);
      // longest command-to-entry gap, so any command before entry has settled
      repeat (MRW_ENTRY_CYC) @(posedge clk);
      fl = core_stat.self_refresh ? FL_SELF : core_stat.banks_open ? FL_ACTIVE : FL_IDLE;
      q.push_back({5'h0, 1'b1, fl});
      // entry even while activate, precharge, refresh or calibration may be busy
      want_low <= 1;
      repeat (14) @(posedge clk);
      #1;
      chk("rx_on", ctl.rx_on, 0);
      chk("bufs_on", ctl.bufs_on, 0);
      chk("refresh_ok", ctl.refresh_ok, fl == FL_SELF);
      chk("pending", pending_ops, |core_stat[3:0]);
      chk("term_on", ctl.term_on, rank_term_en && |termination_mode_field[6:4]);
      q.push_back(8'h00);
      @(posedge clk);
      want_low <= 0;
      repeat (6) @(posedge clk);
      #1 chk("cmd_ok early", ctl.cmd_ok, 0);
      repeat (8) @(posedge clk);
      #1 chk("cmd_ok", {ctl.cmd_ok, ctl.bufs_on}, 2'b11);
    end
    wrap_up();
  end
endmodule
